// [fde_dma.sv]
// frame descriptor dma engine: axi4-lite registers, tx and rx descriptor walkers
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
module fde_dma
  import fde_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // axi4-lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // tx descriptor/buffer memory master
  output fde_pkg::fde_mreq_t tx_mreq,
  input wire fde_pkg::fde_mrsp_t tx_mrsp,
  // rx descriptor/buffer memory master
  output fde_pkg::fde_mreq_t rx_mreq,
  input wire fde_pkg::fde_mrsp_t rx_mrsp,
  // tx word stream to mac and completion
  output fde_pkg::fde_strm_t tx_strm,
  input wire logic tx_strm_ready,
  input wire logic mac_tx_done,
  // rx word stream from mac fifo
  input wire fde_pkg::fde_strm_t rx_strm,
  output logic rx_strm_ready,
  // mac enables for the mac controller
  output logic mac_tx_enable,
  output logic mac_rx_enable
);
  import fde_pkg::*;

  function automatic logic [15:0] sat_sub(input logic [15:0] a, input logic [15:0] b);
    sat_sub = (a > b) ? 16'(a - b) : 16'h0000;
  endfunction

  function automatic logic [31:0] next_desc(input logic [31:0] cur, input logic [31:0] base,
                                            input logic lend);
    next_desc = lend ? base : 32'(cur + DESC_STRIDE);
  endfunction

  function automatic logic [31:0] word_addr(input logic [31:0] desc, input fde_state_t st);
    if (st == ST_RD1) word_addr = 32'(desc + W1_OFS);
    else if (st == ST_RD2) word_addr = 32'(desc + W2_OFS);
    else word_addr = desc;
  endfunction

  // ****************************************
  // register file
  // ****************************************
  logic aw_ok_r, w_ok_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic tx_request_bit_r, rx_request_bit_r;
  logic [31:0] tx_list_start_reg_r, rx_list_start_reg_r;
  logic continuous_rx_select_r, rx_request_keep_r;
  logic swrst_r;
  logic tx_clr, rx_clr, tx_restart, rx_restart;
  fde_state_t tx_st_r, rx_st_r;
  logic [31:0] rd_mux;
  logic wr_fire, wr_hit;

  assign s_awready = !aw_ok_r && !s_bvalid;
  assign s_wready = !w_ok_r && !s_bvalid;
  assign wr_fire = aw_ok_r && w_ok_r && !s_bvalid;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_ok_r <= 1'b1;
        awaddr_r <= s_awaddr;
      end else if (wr_fire) begin
        aw_ok_r <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_ok_r <= 1'b1;
        wdata_r <= s_wdata;
        wstrb_r <= s_wstrb;
      end else if (wr_fire) begin
        w_ok_r <= 1'b0;
      end
    end
  end

  always_comb begin
    wr_hit = 1'b1;
    if (awaddr_r == A_TX_REQ) wr_hit = 1'b1;
    else if (awaddr_r == A_RX_REQ) wr_hit = 1'b1;
    else if (awaddr_r == A_MODE) wr_hit = 1'b1;
    else if (awaddr_r == A_TX_LIST) wr_hit = 1'b1;
    else if (awaddr_r == A_RX_LIST) wr_hit = 1'b1;
    else if (awaddr_r == A_RX_METHOD) wr_hit = 1'b1;
    else if (awaddr_r == A_SWRST) wr_hit = 1'b1;
    else wr_hit = 1'b0;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OK;
    end else if (wr_fire) begin
      s_bvalid <= 1'b1;
      s_bresp <= wr_hit ? RESP_OK : RESP_SLVERR;
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  // configuration; strobes are honoured per byte only on the list addresses
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mac_tx_enable <= 1'b0;
      mac_rx_enable <= 1'b0;
      tx_list_start_reg_r <= 32'h0000_0000;
      rx_list_start_reg_r <= 32'h0000_0000;
      continuous_rx_select_r <= 1'b0;
      rx_request_keep_r <= 1'b0;
      swrst_r <= 1'b0;
    end else begin
      swrst_r <= wr_fire && (awaddr_r == A_SWRST) && wdata_r[B_REQ];
      if (wr_fire) begin
        if (awaddr_r == A_MODE) begin
          mac_tx_enable <= wdata_r[B_MAC_TXEN];
          mac_rx_enable <= wdata_r[B_MAC_RXEN];
        end else if (awaddr_r == A_TX_LIST) begin
          for (int i = 0; i < 4; i++) if (wstrb_r[i]) tx_list_start_reg_r[i*8 +: 8] <= wdata_r[i*8 +: 8];
        end else if (awaddr_r == A_RX_LIST) begin
          for (int i = 0; i < 4; i++) if (wstrb_r[i]) rx_list_start_reg_r[i*8 +: 8] <= wdata_r[i*8 +: 8];
        end else if (awaddr_r == A_RX_METHOD) begin
          continuous_rx_select_r <= wdata_r[B_CONT_RX];
          rx_request_keep_r <= wdata_r[B_REQ_KEEP];
        end
      end
    end
  end

  // request bits: a software set beats an engine clear in the same cycle
  assign tx_restart = wr_fire && (awaddr_r == A_TX_REQ) && wdata_r[B_REQ] && mac_tx_enable;
  assign rx_restart = wr_fire && (awaddr_r == A_RX_REQ) && wdata_r[B_REQ] && mac_rx_enable;
  always_ff @(posedge ref_clk) begin
    if (rst || swrst_r) begin
      tx_request_bit_r <= 1'b0;
      rx_request_bit_r <= 1'b0;
    end else begin
      if (tx_restart) tx_request_bit_r <= 1'b1;
      else if (tx_clr) tx_request_bit_r <= 1'b0;
      if (rx_restart) rx_request_bit_r <= 1'b1;
      else if (rx_clr) rx_request_bit_r <= 1'b0;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (s_araddr == A_TX_REQ) rd_mux[B_REQ] = tx_request_bit_r;
    else if (s_araddr == A_RX_REQ) rd_mux[B_REQ] = rx_request_bit_r;
    else if (s_araddr == A_MODE) rd_mux = {29'h0, mac_rx_enable, mac_tx_enable, 1'b0};
    else if (s_araddr == A_TX_LIST) rd_mux = tx_list_start_reg_r;
    else if (s_araddr == A_RX_LIST) rd_mux = rx_list_start_reg_r;
    else if (s_araddr == A_RX_METHOD) rd_mux = {30'h0, rx_request_keep_r, continuous_rx_select_r};
    else if (s_araddr == A_STATUS) rd_mux = {24'h0, rx_st_r, tx_st_r};
    else rd_mux = 32'h0000_0000;
  end

  assign s_arready = !s_rvalid;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= RESP_OK;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rdata <= rd_mux;
      s_rresp <= (s_araddr <= A_STATUS && s_araddr[1:0] == 2'h0) ? RESP_OK : RESP_SLVERR;
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // transmit walker
  // ****************************************
  logic [31:0] tx_desc_r, tx_w0_r, tx_ptr_r;
  logic [15:0] tx_left_r;
  logic tx_fresh_r;
  logic tx_buf_pending_r;

  always_ff @(posedge ref_clk) begin
    if (rst || swrst_r) begin
      tx_st_r <= ST_IDLE;
      tx_desc_r <= 32'h0000_0000;
      tx_w0_r <= 32'h0000_0000;
      tx_ptr_r <= 32'h0000_0000;
      tx_left_r <= 16'h0000;
      tx_fresh_r <= 1'b1;
      tx_buf_pending_r <= 1'b0;
    end else begin
      case (tx_st_r)
        ST_IDLE: begin
          if (tx_restart) begin
            if (tx_fresh_r) tx_desc_r <= tx_list_start_reg_r;
            tx_fresh_r <= 1'b0;
            tx_st_r <= ST_RD0;
          end
        end
        ST_RD0: begin
          if (tx_mrsp.ack) begin
            tx_w0_r <= tx_mrsp.rdata;
            tx_st_r <= tx_mrsp.rdata[D_ACTIVE] ? ST_RD1 : ST_IDLE;
          end
        end
        ST_RD1: begin
          if (tx_mrsp.ack) begin
            tx_left_r <= tx_mrsp.rdata[D_LEN_HI:D_LEN_LO];
            tx_st_r <= ST_RD2;
          end
        end
        ST_RD2: begin
          if (tx_mrsp.ack) begin
            tx_ptr_r <= tx_mrsp.rdata;
            tx_st_r <= ST_MOVE;
          end
        end
        ST_MOVE: begin
          // one word fetched, then offered to the mac; no prefetch keeps this simple
          if (!tx_buf_pending_r) begin
            if (tx_left_r == 16'h0000) begin
              tx_st_r <= tx_w0_r[D_POS_LO] ? ST_WAIT_DONE : ST_WB;
            end else if (tx_mrsp.ack) begin
              tx_buf_pending_r <= 1'b1;
            end
          end else if (tx_strm_ready) begin
            tx_buf_pending_r <= 1'b0;
            tx_ptr_r <= 32'(tx_ptr_r + 32'(BYTES_PER_WORD));
            tx_left_r <= sat_sub(tx_left_r, BYTES_PER_WORD);
          end
        end
        ST_WAIT_DONE: if (mac_tx_done) tx_st_r <= ST_WB;
        ST_WB: if (tx_mrsp.ack) tx_st_r <= ST_NEXT;
        ST_NEXT: begin
          tx_desc_r <= next_desc(tx_desc_r, tx_list_start_reg_r, tx_w0_r[D_LIST_END]);
          tx_st_r <= ST_RD0;
        end
        default: tx_st_r <= ST_IDLE;
      endcase
    end
  end

  // inactive fetch ends transmit; next request rereads the descriptor found inactive
  assign tx_clr = (tx_st_r == ST_RD0) && tx_mrsp.ack && !tx_mrsp.rdata[D_ACTIVE];

  // word latched from the buffer passes unchanged; only the data goes out, no source address
  always_ff @(posedge ref_clk) begin
    if (rst || swrst_r) begin
      tx_strm <= '0;
    end else if (tx_st_r == ST_MOVE && !tx_buf_pending_r && tx_left_r != 16'h0000 && tx_mrsp.ack) begin
      tx_strm.valid <= 1'b1;
      tx_strm.data <= tx_mrsp.rdata;
      tx_strm.last <= (tx_left_r <= BYTES_PER_WORD) && tx_w0_r[D_POS_LO];
      tx_strm.err <= 1'b0;
    end else if (tx_strm.valid && tx_strm_ready) begin
      tx_strm.valid <= 1'b0;
    end
  end

  always_comb begin
    tx_mreq = '0;
    case (tx_st_r)
      ST_RD0, ST_RD1, ST_RD2: begin
        tx_mreq.req = 1'b1;
        tx_mreq.addr = word_addr(tx_desc_r, tx_st_r);
      end
      ST_MOVE: begin
        tx_mreq.req = !tx_buf_pending_r && tx_left_r != 16'h0000;
        tx_mreq.addr = tx_ptr_r;
      end
      ST_WB: begin
        tx_mreq.req = 1'b1;
        tx_mreq.we = 1'b1;
        tx_mreq.addr = tx_desc_r;
        tx_mreq.wdata = tx_w0_r;
        tx_mreq.wdata[D_ACTIVE] = 1'b0;
      end
      default: tx_mreq = '0;
    endcase
  end

  // ****************************************
  // receive walker
  // ****************************************
  logic [31:0] rx_desc_r, rx_w0_r, rx_ptr_r, rx_word_r;
  logic [15:0] rx_cap_r, rx_len_r;
  logic rx_fresh_r, rx_have_r, rx_end_r, rx_err_r, rx_started_r;
  logic [1:0] rx_pos;

  // first/last flags make the position code
  always_comb begin
    if (!rx_started_r && rx_end_r) rx_pos = POS_ONLY;
    else if (!rx_started_r) rx_pos = POS_FIRST;
    else if (rx_end_r) rx_pos = POS_LAST;
    else rx_pos = POS_CONT;
  end

  assign rx_strm_ready = (rx_st_r == ST_STANDBY || rx_st_r == ST_MOVE) && !rx_have_r
                         && rx_len_r < rx_cap_r;

  always_ff @(posedge ref_clk) begin
    if (rst || swrst_r) begin
      rx_st_r <= ST_IDLE;
      rx_desc_r <= 32'h0000_0000;
      rx_w0_r <= 32'h0000_0000;
      rx_ptr_r <= 32'h0000_0000;
      rx_word_r <= 32'h0000_0000;
      rx_cap_r <= 16'h0000;
      rx_len_r <= 16'h0000;
      rx_fresh_r <= 1'b1;
      rx_have_r <= 1'b0;
      rx_end_r <= 1'b0;
      rx_err_r <= 1'b0;
      rx_started_r <= 1'b0;
    end else begin
      case (rx_st_r)
        ST_IDLE: begin
          if (rx_restart) begin
            if (rx_fresh_r) rx_desc_r <= rx_list_start_reg_r;
            rx_fresh_r <= 1'b0;
            rx_st_r <= ST_RD0;
          end
        end
        ST_RD0: begin
          if (rx_mrsp.ack) begin
            rx_w0_r <= rx_mrsp.rdata;
            if (rx_mrsp.rdata[D_ACTIVE]) rx_st_r <= ST_RD1;
            else if (continuous_rx_select_r && rx_request_keep_r) rx_st_r <= ST_RD0;
            else rx_st_r <= ST_IDLE;
          end
        end
        ST_RD1: begin
          if (rx_mrsp.ack) begin
            rx_cap_r <= rx_mrsp.rdata[D_LEN_HI:D_LEN_LO];
            rx_len_r <= 16'h0000;
            rx_st_r <= ST_RD2;
          end
        end
        ST_RD2: begin
          if (rx_mrsp.ack) begin
            rx_ptr_r <= rx_mrsp.rdata;
            rx_end_r <= 1'b0;
            rx_err_r <= 1'b0;
            rx_st_r <= ST_STANDBY;
          end
        end
        ST_STANDBY, ST_MOVE: begin
          // mac delivers inner frame words only; no preamble or crc reach memory
          if (!rx_have_r && rx_strm.valid && rx_strm_ready) begin
            rx_have_r <= 1'b1;
            rx_word_r <= rx_strm.data;
            rx_end_r <= rx_strm.last;
            rx_err_r <= rx_strm.err;
            rx_st_r <= ST_MOVE;
          end else if (rx_have_r && rx_mrsp.ack) begin
            rx_have_r <= 1'b0;
            rx_ptr_r <= 32'(rx_ptr_r + 32'(BYTES_PER_WORD));
            rx_len_r <= 16'(rx_len_r + BYTES_PER_WORD);
            if (rx_end_r || 16'(rx_len_r + BYTES_PER_WORD) >= rx_cap_r) rx_st_r <= ST_WB;
          end
        end
        ST_WB: begin
          if (rx_mrsp.ack) begin
            rx_started_r <= !rx_end_r;
            rx_st_r <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          rx_desc_r <= next_desc(rx_desc_r, rx_list_start_reg_r, rx_w0_r[D_LIST_END]);
          if (!rx_end_r || continuous_rx_select_r) rx_st_r <= ST_RD0;
          else rx_st_r <= ST_IDLE;
        end
        default: rx_st_r <= ST_IDLE;
      endcase
    end
  end

  assign rx_clr = ((rx_st_r == ST_RD0) && rx_mrsp.ack && !rx_mrsp.rdata[D_ACTIVE]
                   && !(continuous_rx_select_r && rx_request_keep_r))
                  || ((rx_st_r == ST_NEXT) && rx_end_r && !continuous_rx_select_r);

  always_comb begin
    rx_mreq = '0;
    case (rx_st_r)
      ST_RD0, ST_RD1, ST_RD2: begin
        rx_mreq.req = 1'b1;
        rx_mreq.addr = word_addr(rx_desc_r, rx_st_r);
      end
      ST_MOVE: begin
        rx_mreq.req = rx_have_r;
        rx_mreq.we = 1'b1;
        rx_mreq.addr = rx_ptr_r;
        rx_mreq.wdata = rx_word_r;
      end
      ST_WB: begin
        rx_mreq.req = 1'b1;
        rx_mreq.we = 1'b1;
        rx_mreq.addr = rx_desc_r;
        rx_mreq.wdata = rx_w0_r;
        rx_mreq.wdata[D_ACTIVE] = 1'b0;
        rx_mreq.wdata[D_POS_HI:D_POS_LO] = rx_pos;
        rx_mreq.wdata[D_RX_ERR] = rx_err_r;
      end
      default: rx_mreq = '0;
    endcase
  end

endmodule // fde_dma

// [fde_pkg.sv]
// package for the frame descriptor dma engine: register map, descriptor layout, states
package fde_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] A_TX_REQ = 8'h00;
  localparam logic [7:0] A_RX_REQ = 8'h04;
  localparam logic [7:0] A_MODE = 8'h08;
  localparam logic [7:0] A_TX_LIST = 8'h0c;
  localparam logic [7:0] A_RX_LIST = 8'h10;
  localparam logic [7:0] A_RX_METHOD = 8'h14;
  localparam logic [7:0] A_SWRST = 8'h18;
  localparam logic [7:0] A_STATUS = 8'h1c;

  // ****************************************
  // register fields
  // ****************************************
  localparam int B_REQ = 0;
  localparam int B_MAC_TXEN = 1;
  localparam int B_MAC_RXEN = 2;
  localparam int B_CONT_RX = 0;
  localparam int B_REQ_KEEP = 1;

  // ****************************************
  // descriptor layout
  // ****************************************
  localparam int D_ACTIVE = 31;
  localparam int D_LIST_END = 30;
  localparam int D_POS_HI = 29;
  localparam int D_POS_LO = 28;
  localparam int D_RX_ERR = 27;
  localparam int D_LEN_HI = 31;
  localparam int D_LEN_LO = 16;
  localparam logic [31:0] DESC_STRIDE = 32'h0000_0010;
  localparam logic [31:0] W1_OFS = 32'h0000_0004;
  localparam logic [31:0] W2_OFS = 32'h0000_0008;
  localparam logic [1:0] POS_CONT = 2'h0;
  localparam logic [1:0] POS_FIRST = 2'h2;
  localparam logic [1:0] POS_LAST = 2'h1;
  localparam logic [1:0] POS_ONLY = 2'h3;
  localparam logic [15:0] BYTES_PER_WORD = 16'h0004;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // engine states
  // ****************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_RD0 = 4'b0001,
    ST_RD1 = 4'b0010,
    ST_RD2 = 4'b0011,
    ST_MOVE = 4'b0100,
    ST_WAIT_DONE = 4'b0101,
    ST_WB = 4'b0110,
    ST_NEXT = 4'b0111,
    ST_STANDBY = 4'b1000
  } fde_state_t;

  // memory master request and answer
  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } fde_mreq_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } fde_mrsp_t;

  // word stream between engine and mac
  typedef struct packed {
    logic valid;
    logic last;
    logic err;
    logic [31:0] data;
  } fde_strm_t;

endpackage

// [fde_dma_assertions.sv]
// checker: assertions on the ports of fde_dma
`timescale 1ns/1ns
module fde_dma_assertions
  import fde_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // memory masters
  input wire fde_pkg::fde_mreq_t tx_mreq,
  input wire fde_pkg::fde_mrsp_t tx_mrsp,
  input wire fde_pkg::fde_mreq_t rx_mreq,
  input wire fde_pkg::fde_mrsp_t rx_mrsp,
  // mac side
  input wire fde_pkg::fde_strm_t tx_strm,
  input wire logic tx_strm_ready,
  input wire logic mac_tx_done,
  input wire fde_pkg::fde_strm_t rx_strm,
  input wire logic rx_strm_ready,
  input wire logic mac_tx_enable,
  input wire logic mac_rx_enable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // tx word0 write with the active bit cleared
  sequence s_tx_wb;
    tx_mreq.req && tx_mreq.we && !tx_mreq.wdata[D_ACTIVE];
  endsequence
  sequence s_rx_wr;
    rx_mreq.req && rx_mreq.we;
  endsequence
  AST_TXM_HOLD: assert property (tx_mreq.req && !tx_mrsp.ack |=> tx_mreq.req && $stable(tx_mreq))
    else $error("tx memory request not held");
  AST_RXM_HOLD: assert property (rx_mreq.req && !rx_mrsp.ack |=> rx_mreq.req && $stable(rx_mreq))
    else $error("rx memory request not held");
  AST_TXS_HOLD: assert property (tx_strm.valid && !tx_strm_ready |=> tx_strm.valid && $stable(tx_strm))
    else $error("tx word not held");
  AST_TX_EN: assert property ($rose(tx_mreq.req) |-> mac_tx_enable)
    else $error("tx fetch without tx enable");
  AST_RX_EN: assert property ($rose(rx_mreq.req) |-> mac_rx_enable)
    else $error("rx access without rx enable");
  AST_TX_DATA: assert property ($rose(tx_strm.valid) |-> tx_strm.data == $past(tx_mrsp.rdata))
    else $error("tx word differs from buffer word");
  AST_TX_WB: assert property (mac_tx_done |-> ##[1:16] s_tx_wb)
    else $error("no write-back after frame sent");
  AST_RX_WR: assert property (rx_strm.valid && rx_strm_ready |-> ##[0:16] s_rx_wr)
    else $error("rx word not stored");
  AST_TX_ERR: assert property (tx_strm.valid |-> !tx_strm.err)
    else $error("tx word flagged as errored");
endmodule // fde_dma_assertions
bind fde_dma fde_dma_assertions fde_dma_assertions_i (
  .ref_clk(ref_clk), .rst(rst), .tx_mreq(tx_mreq), .tx_mrsp(tx_mrsp), .rx_mreq(rx_mreq), .rx_mrsp(rx_mrsp),
  .tx_strm(tx_strm), .tx_strm_ready(tx_strm_ready), .mac_tx_done(mac_tx_done), .rx_strm(rx_strm),
  .rx_strm_ready(rx_strm_ready), .mac_tx_enable(mac_tx_enable), .mac_rx_enable(mac_rx_enable)
);

// [fde_far.sv]
// partner model: descriptor memory and mac side of fde_dma
`timescale 1ns/1ns
module fde_far
  import fde_pkg::*;
(
  // clock and pacing
  input wire logic ref_clk,
  input wire logic slow,
  // memory ports
  input wire fde_pkg::fde_mreq_t tx_mreq,
  output fde_pkg::fde_mrsp_t tx_mrsp,
  input wire fde_pkg::fde_mreq_t rx_mreq,
  output fde_pkg::fde_mrsp_t rx_mrsp,
  // mac side
  input wire fde_pkg::fde_strm_t tx_strm,
  output logic tx_strm_ready,
  output logic mac_tx_done,
  output fde_pkg::fde_strm_t rx_strm,
  input wire logic rx_strm_ready
);
  logic [31:0] mem [0:255];
  logic [31:0] q_data [$];
  logic q_last [$];
  logic [1:0] cyc = 2'h0;
  logic [3:0] dly = 4'h0;
  wire logic go = !slow || cyc == 2'h3;
  initial begin
    tx_mrsp = '0;
    rx_mrsp = '0;
    tx_strm_ready = 1'b0;
    mac_tx_done = 1'b0;
    rx_strm = '0;
    foreach (mem[i]) mem[i] = 32'h0;
  end
  // idle read data toggles so a stale word is never mistaken for an answer
  always @(posedge ref_clk) begin
    cyc <= cyc + 2'h1;
    if (tx_mreq.req && !tx_mrsp.ack && go) begin
      tx_mrsp <= '{ack: 1'b1, rdata: mem[tx_mreq.addr[9:2]]};
      if (tx_mreq.we) mem[tx_mreq.addr[9:2]] <= tx_mreq.wdata;
    end else tx_mrsp <= '{ack: 1'b0, rdata: ~tx_mrsp.rdata};
    if (rx_mreq.req && !rx_mrsp.ack) begin
      rx_mrsp <= '{ack: 1'b1, rdata: mem[rx_mreq.addr[9:2]]};
      if (rx_mreq.we) mem[rx_mreq.addr[9:2]] <= rx_mreq.wdata;
    end else rx_mrsp <= '{ack: 1'b0, rdata: ~rx_mrsp.rdata};
  end
  // mac stalls one cycle in four; frame sent a few cycles after its last word
  always @(posedge ref_clk) begin
    tx_strm_ready <= cyc != 2'h1;
    mac_tx_done <= dly == 4'h1;
    dly <= (tx_strm.valid && tx_strm_ready && tx_strm.last) ? 4'h4 : (dly != 4'h0 ? dly - 4'h1 : 4'h0);
    if (tx_strm.valid && tx_strm_ready) begin
      q_data.push_back(tx_strm.data);
      q_last.push_back(tx_strm.last);
    end
  end
  // words carry only the inner frame bytes
  task automatic send(input logic [31:0] d0, input int n, input logic e);
    for (int i = 0; i < n; i++) begin
      rx_strm <= '{valid: 1'b1, last: i == n - 1, err: e && i == n - 1, data: d0 + 32'(i)};
      do @(negedge ref_clk); while (!rx_strm_ready);
      @(posedge ref_clk);
    end
    rx_strm <= '{valid: 1'b0, last: 1'b0, err: 1'b0, data: ~rx_strm.data};
  endtask
endmodule // fde_far

// [ethernet_descriptor_dma_tb.sv]
// testbench: register, transmit and receive walks of fde_dma
`timescale 1ns/1ns
module ethernet_descriptor_dma_tb;
  import fde_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic slow = 1'b0;
  logic [7:0] s_awaddr = 8'h00;
  logic [7:0] s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0;
  logic s_awvalid = 1'b0;
  logic s_wvalid = 1'b0;
  logic s_bready = 1'b0;
  logic s_arvalid = 1'b0;
  logic s_rready = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, tx_strm_ready, mac_tx_done, rx_strm_ready;
  logic [1:0] s_rresp, s_bresp, r;
  logic [31:0] s_rdata, rd;
  fde_mreq_t tx_mreq, rx_mreq;
  fde_mrsp_t tx_mrsp, rx_mrsp;
  fde_strm_t tx_strm, rx_strm;
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;
  always #25 ref_clk = ~ref_clk;
  fde_dma fde_dma_i (
    .ref_clk(ref_clk), .rst(rst), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(4'hf), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .tx_mreq(tx_mreq), .tx_mrsp(tx_mrsp), .rx_mreq(rx_mreq), .rx_mrsp(rx_mrsp), .tx_strm(tx_strm),
    .tx_strm_ready(tx_strm_ready), .mac_tx_done(mac_tx_done), .rx_strm(rx_strm),
    .rx_strm_ready(rx_strm_ready), .mac_tx_enable(), .mac_rx_enable()
  );
  fde_far fde_far_i (
    .ref_clk(ref_clk), .slow(slow), .tx_mreq(tx_mreq), .tx_mrsp(tx_mrsp), .rx_mreq(rx_mreq),
    .rx_mrsp(rx_mrsp), .tx_strm(tx_strm), .tx_strm_ready(tx_strm_ready), .mac_tx_done(mac_tx_done),
    .rx_strm(rx_strm), .rx_strm_ready(rx_strm_ready)
  );
  // ********
  // bus tasks and checks
  // ********
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge ref_clk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(negedge ref_clk);
      aw = s_awvalid && s_awready;
      w = s_wvalid && s_wready;
      b = s_bvalid;
      r = s_bresp;
      @(posedge ref_clk);
      if (aw) s_awvalid <= 1'b0;
      if (w) s_wvalid <= 1'b0;
    end while (!b);
    s_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    logic t, v;
    @(posedge ref_clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(negedge ref_clk);
      t = s_arvalid && s_arready;
      v = s_rvalid;
      rd = s_rdata;
      r = s_rresp;
      @(posedge ref_clk);
      if (t) s_arvalid <= 1'b0;
    end while (!v);
    s_rready <= 1'b0;
  endtask
  // polls a request bit; the bound keeps a stuck engine from hanging here
  task automatic wait_req(input logic [7:0] a, input logic [31:0] v);
    for (int k = 0; k < 60; k++) begin
      axi_rd(a);
      if (rd === v) break;
    end
  endtask
  task automatic desc(input int i, input logic [31:0] w0, w1, w2);
    fde_far_i.mem[i] = w0;
    fde_far_i.mem[i+1] = w1;
    fde_far_i.mem[i+2] = w2;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      conclude();
    end
  end
  // ********
  // tests
  // ********
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    axi_wr(A_MODE, 32'h0);
    axi_wr(A_TX_REQ, 32'h1);
    axi_rd(A_TX_REQ);
    chk(rd, 32'h0);
    axi_rd(8'h20);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    axi_wr(A_STATUS, 32'h0);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    axi_wr(A_MODE, 32'h6);
    chk({30'h0, r}, {30'h0, RESP_OK});
    axi_rd(A_MODE);
    chk(rd, 32'h6);
    $display("test registers done");
    // two-descriptor frame, the second closes the ring
    for (int i = 0; i < 2; i++) fde_far_i.mem[8'h80 + i] = 32'ha5a5_0080 + 32'(i);
    fde_far_i.mem[8'h90] = 32'h5a5a_0090;
    desc(8'h40, 32'ha000_0000, 32'h0008_0000, 32'h0000_0200);
    desc(8'h44, 32'hd000_0000, 32'h0004_0000, 32'h0000_0240);
    axi_wr(A_TX_LIST, 32'h100);
    axi_wr(A_SWRST, 32'h1);
    axi_wr(A_TX_REQ, 32'h1);
    wait_req(A_TX_REQ, 32'h0);
    chk(rd, 32'h0);
    chk(32'(fde_far_i.q_data.size()), 32'h3);
    chk(fde_far_i.q_data[0], 32'ha5a5_0080);
    chk(fde_far_i.q_data[1], 32'ha5a5_0081);
    chk(fde_far_i.q_data[2], 32'h5a5a_0090);
    chk({31'h0, fde_far_i.q_last[2]}, 32'h1);
    chk(fde_far_i.mem[8'h40] & 32'h8000_0000, 32'h0);
    chk(fde_far_i.mem[8'h44] & 32'h8000_0000, 32'h0);
    $display("test tx walk done");
    // resume after the ring wrapped, with a slow memory
    fde_far_i.q_data.delete();
    slow <= 1'b1;
    fde_far_i.mem[8'ha0] = 32'hc3c3_00a0;
    desc(8'h40, 32'hb000_0000, 32'h0004_0000, 32'h0000_0280);
    axi_wr(A_TX_REQ, 32'h1);
    wait_req(A_TX_REQ, 32'h0);
    chk(rd, 32'h0);
    chk(32'(fde_far_i.q_data.size()), 32'h1);
    chk(fde_far_i.q_data[0], 32'hc3c3_00a0);
    slow <= 1'b0;
    $display("test tx resume done");
    // frame longer than the first buffer, continuous reception
    desc(8'h60, 32'h8000_0000, 32'h0008_0000, 32'h0000_0300);
    desc(8'h64, 32'h8000_0000, 32'h0010_0000, 32'h0000_0340);
    desc(8'h68, 32'h0, 32'h0010_0000, 32'h0000_0380);
    axi_wr(A_RX_LIST, 32'h180);
    axi_wr(A_SWRST, 32'h1);
    axi_wr(A_RX_METHOD, 32'h1);
    axi_wr(A_RX_REQ, 32'h1);
    fde_far_i.send(32'h7e00_0000, 3, 1'b0);
    wait_req(A_RX_REQ, 32'h0);
    chk(rd, 32'h0);
    chk(fde_far_i.mem[8'hc1], 32'h7e00_0001);
    chk(fde_far_i.mem[8'hd0], 32'h7e00_0002);
    chk(fde_far_i.mem[8'h60] & 32'hb000_0000, 32'h2000_0000);
    chk(fde_far_i.mem[8'h64] & 32'hb800_0000, 32'h1000_0000);
    $display("test rx walk done");
    // errored frame after re-request, request kept on an inactive descriptor
    desc(8'h68, 32'h8000_0000, 32'h0010_0000, 32'h0000_0380);
    axi_wr(A_RX_METHOD, 32'h3);
    axi_wr(A_RX_REQ, 32'h1);
    fde_far_i.send(32'h3c00_0000, 1, 1'b1);
    for (int k = 0; k < 200 && fde_far_i.mem[8'h68][31]; k++) @(posedge ref_clk);
    axi_rd(A_RX_REQ);
    chk(rd, 32'h1);
    chk(fde_far_i.mem[8'he0], 32'h3c00_0000);
    chk(fde_far_i.mem[8'h68] & 32'hb800_0000, 32'h3800_0000);
    $display("test rx error done");
    conclude();
  end
endmodule // ethernet_descriptor_dma_tb
